// [scl_cfg.svh]
// Constants of the serial command-line port: character codes, sizes and timing.
// Assumes it is included by bare name from the port, monitor, host model and testbench files.
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

`define SCL_CLK_HZ 125000000
`define SCL_BAUD 9600
`define SCL_DATA_BITS 8
`define SCL_LINE_MAX 7'h7F
`define SCL_LINE_DEPTH 128
`define SCL_RESP_DEPTH 4
`define SCL_ECHO_DEPTH 8
`define SCL_ECHO_DEFAULT 1'b1
`define SCL_FLOW_DEFAULT 1'b0

`define SCL_CH_BS 8'h08
`define SCL_CH_LF 8'h0A
`define SCL_CH_CR 8'h0D
`define SCL_CH_XON 8'h11
`define SCL_CH_XOFF 8'h13
`define SCL_CH_NAK 8'h15
`define SCL_CH_CAN 8'h18
`define SCL_CH_ESC 8'h1B
`define SCL_CH_CTRL_MAX 8'h1F
`define SCL_CH_SPACE 8'h20
`define SCL_CH_BANG 8'h21

`define SCL_QUEUE_ERR_CODE 16'hFE70

`endif

// [scl_pkg.sv]
// Types shared by the serial command-line port.
// Assumes scl_cfg.svh holds all numeric constants.
package scl_pkg;

  typedef struct packed {
    logic [7:0] ch;
    logic last;
  } scl_line_t;

  typedef struct packed {
    logic post;
    logic [15:0] code;
  } scl_err_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scl_rx_state_t;

  typedef enum logic [2:0] {LN_FILL, LN_READ, LN_WAIT, LN_OUT, LN_DONE, LN_REPLY} scl_line_state_t;

endpackage

// [scl_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module scl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("scl_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic inReady_reg;
  logic push;
  logic pop;

  assign push = inValid && inReady_reg;
  assign pop = outValid && outReady;
  assign inReady = inReady_reg;
  assign outValid = (count_reg != '0);
  assign outData = store[rdPtr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Ready is registered so the source never sees a combinational path through this FIFO.
  always_ff @(posedge clk_sys) begin
    if (srst || flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady_reg <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      inReady_reg <= (count_next != (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr_reg] <= inData;
    end
  end
endmodule
`default_nettype wire

// [scl_line_mem.sv]
// Line buffer memory: one write port, one read port with registered data.
// Assumes one clock; contents are undefined until written.
`timescale 1ns/1ps
`default_nettype none
module scl_line_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    rdData <= cells[rdAddr];
  end
endmodule
`default_nettype wire

// [scl_port.sv]
// Serial command-line port: UART receiver and transmitter, line buffer, control characters.
// Assumes a parser drains the line stream and pulses parseDone once the line is executed.
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"
module scl_port #(
  parameter int CLKS_PER_BIT = `SCL_CLK_HZ / `SCL_BAUD,
  parameter int LINE_DEPTH = `SCL_LINE_DEPTH,
  parameter int RESP_DEPTH = `SCL_RESP_DEPTH
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic echoEnable,
  input wire logic flowCtrlEnable,
  output scl_pkg::scl_line_t lineOut,
  output logic lineValid,
  input wire logic lineReady,
  input wire logic parseDone,
  input wire logic [7:0] respData,
  input wire logic respValid,
  output logic respReady,
  output scl_pkg::scl_err_t queueLossError,
  output logic overflowFlag,
  output logic txHalted
);
  if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 65535) begin : g_bad_baud
    $error("scl_port CLKS_PER_BIT out of range");
  end
  if (LINE_DEPTH != 128) begin : g_bad_line
    $error("scl_port line buffer must hold 127 characters plus terminator");
  end

  localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_BIT = 16'(CLKS_PER_BIT / 2 - 1);

  function automatic logic isTerm(input logic [7:0] ch);
    isTerm = (ch == `SCL_CH_CR) || (ch == `SCL_CH_LF);
  endfunction

  // ---------------- Receiver ----------------
  logic rxSync1_reg;
  logic rxSync2_reg;
  scl_pkg::scl_rx_state_t rxState_reg;
  logic [15:0] rxCnt_reg;
  logic [2:0] rxBit_reg;
  logic [7:0] rxShift_reg;
  logic rxStrobe_reg;
  logic [7:0] rxByte_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxSync1_reg <= 1'b1;
      rxSync2_reg <= 1'b1;
    end else begin
      rxSync1_reg <= rxdPin;
      rxSync2_reg <= rxSync1_reg;
    end
  end

  // A start bit is confirmed at mid-bit; a bad stop bit drops the character.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxState_reg <= scl_pkg::RX_IDLE;
      rxCnt_reg <= 16'h0000;
      rxBit_reg <= 3'h0;
      rxShift_reg <= 8'h00;
      rxStrobe_reg <= 1'b0;
      rxByte_reg <= 8'h00;
    end else begin
      rxStrobe_reg <= 1'b0;
      unique case (rxState_reg)
        scl_pkg::RX_IDLE: begin
          if (!rxSync2_reg) begin
            rxState_reg <= scl_pkg::RX_START;
            rxCnt_reg <= HALF_BIT;
          end
        end
        scl_pkg::RX_START: begin
          if (rxCnt_reg != 16'h0000) begin
            rxCnt_reg <= rxCnt_reg - 16'h0001;
          end else if (!rxSync2_reg) begin
            rxState_reg <= scl_pkg::RX_DATA;
            rxCnt_reg <= BIT_LAST;
            rxBit_reg <= 3'h0;
          end else begin
            rxState_reg <= scl_pkg::RX_IDLE;
          end
        end
        scl_pkg::RX_DATA: begin
          if (rxCnt_reg != 16'h0000) begin
            rxCnt_reg <= rxCnt_reg - 16'h0001;
          end else begin
            rxShift_reg <= {rxSync2_reg, rxShift_reg[7:1]};
            rxCnt_reg <= BIT_LAST;
            rxBit_reg <= rxBit_reg + 3'h1;
            if (rxBit_reg == 3'h7) begin
              rxState_reg <= scl_pkg::RX_STOP;
            end
          end
        end
        scl_pkg::RX_STOP: begin
          if (rxCnt_reg != 16'h0000) begin
            rxCnt_reg <= rxCnt_reg - 16'h0001;
          end else begin
            rxState_reg <= scl_pkg::RX_IDLE;
            rxStrobe_reg <= rxSync2_reg;
            rxByte_reg <= rxShift_reg;
          end
        end
      endcase
    end
  end

  // ---------------- Character decode ----------------
  scl_pkg::scl_line_state_t lnState_reg;
  logic [6:0] lnCount_reg;
  logic [6:0] rdIdx_reg;
  logic [7:0] lastTerm_reg;
  logic xoff_reg;
  logic bangPending_reg;
  logic [23:0] pend_reg;
  logic [1:0] pendLen_reg;
  logic lineBusy;
  logic halted;

  logic canHit;
  logic escHit;
  logic bsHit;
  logic termHit;
  logic storeHit;
  logic ovfHit;
  logic xonHit;
  logic xoffHit;
  logic [1:0] loadLen;
  logic [23:0] loadData;

  assign lineBusy = (lnState_reg != scl_pkg::LN_FILL);
  assign halted = flowCtrlEnable && xoff_reg;

  always_comb begin
    canHit = 1'b0;
    escHit = 1'b0;
    bsHit = 1'b0;
    termHit = 1'b0;
    storeHit = 1'b0;
    ovfHit = 1'b0;
    xonHit = 1'b0;
    xoffHit = 1'b0;
    loadLen = 2'h0;
    loadData = 24'h000000;
    if (rxStrobe_reg) begin
      if (rxByte_reg == `SCL_CH_CAN) begin
        canHit = 1'b1;
      end else if (rxByte_reg == `SCL_CH_ESC) begin
        escHit = 1'b1;
        loadLen = 2'h2;
        loadData = {`SCL_CH_CR, `SCL_CH_LF, 8'h00};
      end else if (rxByte_reg == `SCL_CH_BS) begin
        bsHit = 1'b1;
        if (echoEnable) begin
          loadLen = 2'h3;
          loadData = {`SCL_CH_BS, `SCL_CH_SPACE, `SCL_CH_BS};
        end
      end else if (isTerm(rxByte_reg)) begin
        if (isTerm(lastTerm_reg) && lastTerm_reg != rxByte_reg) begin
          loadLen = 2'h0;
        end else if (lineBusy) begin
          ovfHit = 1'b1;
        end else begin
          termHit = 1'b1;
          if (flowCtrlEnable) begin
            loadLen = echoEnable ? 2'h2 : 2'h1;
            loadData = {`SCL_CH_XOFF, `SCL_CH_CR, 8'h00};
          end else if (echoEnable) begin
            loadLen = 2'h1;
            loadData = {rxByte_reg, 16'h0000};
          end
        end
      end else if (rxByte_reg == `SCL_CH_XON) begin
        xonHit = flowCtrlEnable;
      end else if (rxByte_reg == `SCL_CH_XOFF) begin
        xoffHit = 1'b1;
      end else if (rxByte_reg > `SCL_CH_CTRL_MAX) begin
        if (lineBusy || lnCount_reg == `SCL_LINE_MAX) begin
          ovfHit = 1'b1;
          if (echoEnable) begin
            loadLen = 2'h1;
            loadData = {`SCL_CH_NAK, 16'h0000};
          end
        end else begin
          storeHit = 1'b1;
          if (echoEnable) begin
            loadLen = 2'h1;
            loadData = {rxByte_reg, 16'h0000};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || canHit) begin
      lastTerm_reg <= 8'h00;
    end else if (rxStrobe_reg) begin
      if (isTerm(rxByte_reg) && !(isTerm(lastTerm_reg) && lastTerm_reg != rxByte_reg)) begin
        lastTerm_reg <= rxByte_reg;
      end else begin
        lastTerm_reg <= 8'h00;
      end
    end
  end

  // ---------------- Line buffer and hand-off ----------------
  logic [7:0] memRdData;

  scl_line_mem #(
    .WIDTH(8),
    .DEPTH(LINE_DEPTH)
  ) u_line_mem (
    .clk_sys(clk_sys),
    .wrEn(storeHit || termHit),
    .wrAddr(lnCount_reg),
    .wrData(rxByte_reg),
    .rdAddr(rdIdx_reg),
    .rdData(memRdData)
  );

  // The terminator is stored after the text, so the parser sees it flagged as last.
  always_ff @(posedge clk_sys) begin
    if (srst || canHit) begin
      lnState_reg <= scl_pkg::LN_FILL;
      lnCount_reg <= 7'h00;
      rdIdx_reg <= 7'h00;
      lineValid <= 1'b0;
      lineOut <= '0;
    end else begin
      unique case (lnState_reg)
        scl_pkg::LN_FILL: begin
          if (escHit) begin
            lnCount_reg <= 7'h00;
          end else if (bsHit && lnCount_reg != 7'h00) begin
            lnCount_reg <= lnCount_reg - 7'h01;
          end else if (storeHit) begin
            lnCount_reg <= lnCount_reg + 7'h01;
          end else if (termHit) begin
            lnState_reg <= scl_pkg::LN_READ;
            rdIdx_reg <= 7'h00;
          end
        end
        scl_pkg::LN_READ: begin
          lnState_reg <= scl_pkg::LN_WAIT;
        end
        scl_pkg::LN_WAIT: begin
          lineOut.ch <= memRdData;
          lineOut.last <= (rdIdx_reg == lnCount_reg);
          lineValid <= 1'b1;
          lnState_reg <= scl_pkg::LN_OUT;
        end
        scl_pkg::LN_OUT: begin
          if (lineReady) begin
            lineValid <= 1'b0;
            if (rdIdx_reg == lnCount_reg) begin
              lnState_reg <= scl_pkg::LN_DONE;
            end else begin
              rdIdx_reg <= rdIdx_reg + 7'h01;
              lnState_reg <= scl_pkg::LN_READ;
            end
          end
        end
        scl_pkg::LN_DONE: begin
          if (parseDone) begin
            lnState_reg <= scl_pkg::LN_REPLY;
          end
        end
        scl_pkg::LN_REPLY: begin
          if (pendLen_reg == 2'h0 && loadLen == 2'h0) begin
            lnState_reg <= scl_pkg::LN_FILL;
            lnCount_reg <= 7'h00;
          end
        end
      endcase
    end
  end

  // ---------------- Echo staging ----------------
  // Up to three echo bytes are staged and moved one per cycle into the echo FIFO.
  // A new sequence arriving while one is still staged is dropped; at line rate this
  // happens when the echo FIFO is held full by XOFF or filled by back-to-back backspace echoes.
  logic echoInReady;
  logic echoOutValid;
  logic [7:0] echoOutData;
  logic echoPop;
  logic replyLoad;

  assign replyLoad = (lnState_reg == scl_pkg::LN_REPLY) && pendLen_reg == 2'h0 && loadLen == 2'h0;

  always_ff @(posedge clk_sys) begin
    if (srst || canHit) begin
      pendLen_reg <= 2'h0;
      pend_reg <= 24'h000000;
    end else if (pendLen_reg != 2'h0) begin
      if (echoInReady) begin
        pend_reg <= {pend_reg[15:0], 8'h00};
        pendLen_reg <= pendLen_reg - 2'h1;
      end
    end else if (loadLen != 2'h0) begin
      pend_reg <= loadData;
      pendLen_reg <= loadLen;
    end else if (replyLoad) begin
      pend_reg <= {`SCL_CH_CR, `SCL_CH_LF, 8'h00};
      pendLen_reg <= 2'h2;
    end
  end

  scl_fifo #(
    .WIDTH(8),
    .DEPTH(`SCL_ECHO_DEPTH)
  ) u_echo_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .flush(canHit),
    .inValid(pendLen_reg != 2'h0),
    .inData(pend_reg[23:16]),
    .inReady(echoInReady),
    .outValid(echoOutValid),
    .outData(echoOutData),
    .outReady(echoPop)
  );

  // ---------------- Response queue ----------------
  logic respOutValid;
  logic [7:0] respOutData;
  logic respPop;

  scl_fifo #(
    .WIDTH(8),
    .DEPTH(RESP_DEPTH)
  ) u_resp_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .flush(canHit),
    .inValid(respValid),
    .inData(respData),
    .inReady(respReady),
    .outValid(respOutValid),
    .outData(respOutData),
    .outReady(respPop)
  );

  // ---------------- Flow control and errors ----------------
  always_ff @(posedge clk_sys) begin
    if (srst || canHit || !flowCtrlEnable) begin
      xoff_reg <= 1'b0;
    end else if (xoffHit) begin
      xoff_reg <= 1'b1;
    end else if (xonHit) begin
      xoff_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txHalted <= 1'b0;
    end else begin
      txHalted <= halted;
    end
  end

  logic bangStart;

  always_ff @(posedge clk_sys) begin
    if (srst || canHit) begin
      bangPending_reg <= 1'b0;
    end else if (xonHit && xoff_reg) begin
      bangPending_reg <= 1'b1;
    end else if (bangStart) begin
      bangPending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      queueLossError.post <= 1'b0;
      queueLossError.code <= `SCL_QUEUE_ERR_CODE;
    end else begin
      queueLossError.post <= xoffHit || ovfHit;
    end
  end

  // A new overflow wins over the CAN that clears the flag.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      overflowFlag <= 1'b0;
    end else if (ovfHit) begin
      overflowFlag <= 1'b1;
    end else if (canHit) begin
      overflowFlag <= 1'b0;
    end
  end

  // ---------------- Transmitter ----------------
  logic txBusy_reg;
  logic [15:0] txCnt_reg;
  logic [3:0] txBit_reg;
  logic [9:0] txShift_reg;
  logic txStart;
  logic [7:0] txChar;

  // Echo goes first, then responses; the mark follows only once both are empty.
  always_comb begin
    echoPop = 1'b0;
    respPop = 1'b0;
    bangStart = 1'b0;
    txChar = 8'h00;
    if (!txBusy_reg && !halted && !txHalted) begin
      if (echoOutValid) begin
        echoPop = 1'b1;
        txChar = echoOutData;
      end else if (respOutValid) begin
        respPop = 1'b1;
        txChar = respOutData;
      end else if (bangPending_reg) begin
        bangStart = 1'b1;
        txChar = `SCL_CH_BANG;
      end
    end
  end
  assign txStart = echoPop || respPop || bangStart;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txBusy_reg <= 1'b0;
      txCnt_reg <= 16'h0000;
      txBit_reg <= 4'h0;
      txShift_reg <= 10'h3FF;
      txdPin <= 1'b1;
    end else if (txStart) begin
      txBusy_reg <= 1'b1;
      txCnt_reg <= BIT_LAST;
      txBit_reg <= 4'h0;
      txShift_reg <= {1'b1, txChar, 1'b0};
      txdPin <= 1'b0;
    end else if (txBusy_reg) begin
      if (txCnt_reg != 16'h0000) begin
        txCnt_reg <= txCnt_reg - 16'h0001;
      end else if (txBit_reg == 4'h9) begin
        txBusy_reg <= 1'b0;
        txdPin <= 1'b1;
      end else begin
        txCnt_reg <= BIT_LAST;
        txBit_reg <= txBit_reg + 4'h1;
        txShift_reg <= {1'b1, txShift_reg[9:1]};
        txdPin <= txShift_reg[1];
      end
    end
  end
endmodule
`default_nettype wire

// [scl_port_monitor.sv]
// Assertion checker for the serial command-line port, bound onto scl_port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"
module scl_port_monitor #(
  parameter int CLKS_PER_BIT = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic txdPin,
  input wire logic flowCtrlEnable,
  input wire scl_pkg::scl_line_t lineOut,
  input wire logic lineValid,
  input wire logic lineReady,
  input wire scl_pkg::scl_err_t queueLossError,
  input wire logic overflowFlag,
  input wire logic txHalted
);
  localparam int QUIET = 10 * CLKS_PER_BIT;
  logic [15:0] highRun;

  // A start bit inside a frame never follows a full frame of idle line, so a long run marks true idleness.
  always_ff @(posedge clk_sys) begin
    if (srst || !txdPin) begin
      highRun <= 16'h0000;
    end else if (highRun != 16'hFFFF) begin
      highRun <= highRun + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking

  a_reset_idle: assert property (srst |=> txdPin && !lineValid && !overflowFlag && !txHalted)
    else $error("outputs not idle after reset");
  a_line_hold: assert property (disable iff (srst) lineValid && !lineReady |=> lineValid && $stable(lineOut))
    else $error("line character dropped before it was taken");
  a_last_is_term: assert property (disable iff (srst) lineValid && lineOut.last |->
    (lineOut.ch == `SCL_CH_CR || lineOut.ch == `SCL_CH_LF))
    else $error("line ended by a non-terminator");
  a_no_ctrl_stored: assert property (disable iff (srst) lineValid && !lineOut.last |-> lineOut.ch > `SCL_CH_CTRL_MAX)
    else $error("control code handed on as line text");
  a_err_code: assert property (disable iff (srst) queueLossError.post |-> queueLossError.code == `SCL_QUEUE_ERR_CODE)
    else $error("queue loss error posted with wrong code");
  a_err_pulse: assert property (disable iff (srst) queueLossError.post |=> !queueLossError.post)
    else $error("queue loss error post longer than one cycle");
  a_halt_flow: assert property (disable iff (srst) !flowCtrlEnable |=> !txHalted)
    else $error("transmitter halted with flow control off");
  a_halt_quiet: assert property (disable iff (srst)
    txHalted && $past(txHalted) && int'(highRun) >= QUIET |=> txdPin)
    else $error("frame started while halted");
endmodule
`default_nettype wire

// [scl_host_model.sv]
// Behavioural host terminal: sends 8N1 characters and collects what the port transmits.
// Assumes the testbench calls send and reads rxQ hierarchically.
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"
module scl_host_model #(
  parameter int CLKS_PER_BIT = 16
) (
  input wire logic clk_sys,
  input wire logic txdPin,
  input wire logic flowOn,
  output logic rxdPin
);
  logic [7:0] rxQ[$];
  logic paused;
  int badStops;

  initial begin
    rxdPin = 1'b1;
    paused = 1'b0;
    badStops = 0;
  end

  task automatic send(input logic [7:0] c);
    logic [9:0] frame;
    int guard;
    frame = {1'b1, c, 1'b0};
    guard = 0;
    while (paused && flowOn && guard < 4000) begin
      @(posedge clk_sys);
      guard++;
    end
    for (int b = 0; b < 10; b++) begin
      @(posedge clk_sys);
      rxdPin <= frame[b];
      repeat (CLKS_PER_BIT - 1) @(posedge clk_sys);
    end
  endtask

  // Samples at mid-bit, well away from the port's bit transitions.
  always begin
    logic [7:0] d;
    @(negedge txdPin);
    repeat (CLKS_PER_BIT / 2) @(posedge clk_sys);
    for (int b = 0; b < 8; b++) begin
      repeat (CLKS_PER_BIT) @(posedge clk_sys);
      d[b] = txdPin;
    end
    repeat (CLKS_PER_BIT) @(posedge clk_sys);
    if (txdPin !== 1'b1) badStops++;
    rxQ.push_back(d);
    if (d == `SCL_CH_XOFF) paused = 1'b1;
    if (d == `SCL_CH_XON) paused = 1'b0;
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the serial command-line port with a host model on the link.
// Assumes a shortened bit time; the bench plays the parser and the response source.
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"
module tb_top;
  localparam int CLKS_PER_BIT = 16;
  typedef struct packed {logic echo; logic [7:0] ch; logic [2:0] n; logic [31:0] exp;} scl_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic rxdPin, txdPin, lineValid, respReady, overflowFlag, txHalted;
  logic echoEnable = 1'b1;
  logic flowCtrlEnable = 1'b0;
  logic lineReady = 1'b1;
  logic parseDone = 1'b0;
  logic [7:0] respData = 8'h00;
  logic respValid = 1'b0;
  logic hostFlow = 1'b0;
  scl_pkg::scl_line_t lineOut;
  scl_pkg::scl_err_t queueLossError;
  logic [8:0] lineQ[$];
  int nMismatch = 0;
  int checksDone = 0;
  int nPost = 0;
  scl_row_t rows[9] = '{
    '{1'b0, 8'h4D, 3'h0, 32'h0},
    '{1'b0, 8'h1B, 3'h2, 32'h0D0A0000},
    '{1'b1, 8'h01, 3'h0, 32'h0},
    '{1'b1, 8'h41, 3'h1, 32'h41000000},
    '{1'b1, 8'h58, 3'h1, 32'h58000000},
    '{1'b1, 8'h08, 3'h3, 32'h08200800},
    '{1'b1, 8'h42, 3'h1, 32'h42000000},
    '{1'b1, 8'h0D, 3'h1, 32'h0D000000},
    '{1'b1, 8'h0A, 3'h0, 32'h0}};

  always #4 clk_sys = ~clk_sys;

  scl_port #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_scl_port (.clk_sys(clk_sys), .srst(srst), .rxdPin(rxdPin),
    .txdPin(txdPin), .echoEnable(echoEnable), .flowCtrlEnable(flowCtrlEnable), .lineOut(lineOut),
    .lineValid(lineValid), .lineReady(lineReady), .parseDone(parseDone), .respData(respData),
    .respValid(respValid), .respReady(respReady), .queueLossError(queueLossError),
    .overflowFlag(overflowFlag), .txHalted(txHalted));
  scl_host_model #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_host (.clk_sys(clk_sys), .txdPin(txdPin),
    .flowOn(hostFlow), .rxdPin(rxdPin));

  always @(posedge clk_sys) begin
    if (lineValid === 1'b1 && lineReady === 1'b1) lineQ.push_back(lineOut);
    if (queueLossError.post === 1'b1) nPost++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_rx(input int n, input logic [31:0] exp);
    repeat (800) @(posedge clk_sys);
    chk("echo count", n, u_host.rxQ.size());
    for (int k = 0; k < n; k++) chk("echo byte", exp[31-8*k -: 8], u_host.rxQ[k]);
    u_host.rxQ.delete();
  endtask

  task automatic pulse_parsed();
    @(posedge clk_sys);
    parseDone <= 1'b1;
    @(posedge clk_sys);
    parseDone <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    nMismatch++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("idle outputs", 32'h3000, {txdPin, respReady, lineValid, overflowFlag, txHalted, lineOut});
    for (int i = 0; i < 9; i++) begin
      echoEnable <= rows[i].echo;
      u_host.send(rows[i].ch);
      expect_rx(rows[i].n, rows[i].exp);
    end
    chk("line length", 3, lineQ.size());
    chk("line text", {8'h41, 1'b0, 8'h42, 1'b0, 8'h0D, 1'b1}, {lineQ[0], lineQ[1], lineQ[2]});
    pulse_parsed();
    expect_rx(2, 32'h0D0A0000);
    flowCtrlEnable <= 1'b1;
    nPost = 0;
    u_host.send(`SCL_CH_XOFF);
    repeat (40) @(posedge clk_sys);
    chk("halted", 1, txHalted);
    chk("error posts", 1, nPost);
    respData <= 8'h5A;
    respValid <= 1'b1;
    @(posedge clk_sys);
    respValid <= 1'b0;
    u_host.rxQ.delete();
    repeat (600) @(posedge clk_sys);
    chk("held output", 0, u_host.rxQ.size());
    u_host.send(`SCL_CH_XON);
    repeat (800) @(posedge clk_sys);
    chk("halted", 0, txHalted);
    chk("drain tail", 16'h5A21, {u_host.rxQ[$-1], u_host.rxQ[$]});
    u_host.rxQ.delete();
    hostFlow <= 1'b1;
    u_host.send(`SCL_CH_CR);
    pulse_parsed();
    expect_rx(4, 32'h130D0D0A);
    echoEnable <= 1'b0;
    hostFlow <= 1'b0;
    u_host.send(`SCL_CH_CR);
    pulse_parsed();
    expect_rx(3, 32'h130D0A00);
    echoEnable <= 1'b1;
    flowCtrlEnable <= 1'b0;
    nPost = 0;
    repeat (127) u_host.send(8'h61);
    repeat (600) @(posedge clk_sys);
    chk("overflow", 0, overflowFlag);
    u_host.send(8'h61);
    repeat (600) @(posedge clk_sys);
    chk("overflow", 1, overflowFlag);
    chk("loss marker", `SCL_CH_NAK, u_host.rxQ[$]);
    chk("error posts", 1, nPost);
    u_host.send(`SCL_CH_CAN);
    repeat (300) @(posedge clk_sys);
    chk("overflow", 0, overflowFlag);
    lineQ.delete();
    lineReady <= 1'b0;
    u_host.send(8'h51);
    u_host.send(`SCL_CH_CR);
    repeat (600) @(posedge clk_sys);
    chk("held line char", {1'b1, 8'h51, 1'b0}, {lineValid, lineOut});
    lineReady <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("line after cancel", {8'h51, 1'b0, 8'h0D, 1'b1}, {lineQ[0], lineQ[1]});
    chk("stop bits", 0, u_host.badStops);
    results();
  end
endmodule

bind scl_port scl_port_monitor #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_mon (.clk_sys(clk_sys), .srst(srst),
  .txdPin(txdPin), .flowCtrlEnable(flowCtrlEnable), .lineOut(lineOut), .lineValid(lineValid),
  .lineReady(lineReady), .queueLossError(queueLossError), .overflowFlag(overflowFlag), .txHalted(txHalted));
`default_nettype wire
